// [core/smsp_consts.svh]
// Constants for the SPI master/slave port: register offsets, field
// positions, reset values and timing counts.
// Assumes inclusion by bare name from the package and the core module.
`ifndef SMSP_CONSTS_SVH
`define SMSP_CONSTS_SVH

`define SMSP_OFF_CTRL 12'h000
`define SMSP_OFF_STAT 12'h004
`define SMSP_OFF_DATA 12'h008

`define SMSP_CTRL_RATE_HI 7
`define SMSP_CTRL_ENABLE 6
`define SMSP_CTRL_SELDIS 5
`define SMSP_CTRL_MASTER 4
`define SMSP_CTRL_POL 3
`define SMSP_CTRL_PHASE 2
`define SMSP_CTRL_RATE_MID 1
`define SMSP_CTRL_RATE_LO 0

`define SMSP_STAT_DONE 7
`define SMSP_STAT_WRITE_COLLISION_FLAG 6
`define SMSP_STAT_MODE_FAULT_FLAG 4

`define SMSP_CTRL_RESET 8'h00
`define SMSP_BITS_PER_BYTE 4'h8
`define SMSP_SEL_SYNC_STAGES 2

`endif

// [core/smsp_pkg.sv]
// Types shared by the SPI port core and its shift engine.
// Assumes the constants header sits in the include path.
`include "smsp_consts.svh"

package smsp_pkg;
  typedef enum logic [2:0] {
    SMSP_IDLE = 3'b001,
    SMSP_LEAD = 3'b010,
    SMSP_TRAIL = 3'b100
  } smsp_state_t;

  typedef logic [7:0] smsp_byte_t;
endpackage

// [core/smsp_shift_if.sv]
// Interface between the register core and the shift engine.
// Assumes one clock shared by both ends.
`timescale 1ns/100ps

interface smsp_shift_if;
  logic start;
  logic [7:0] txByte;
  logic [7:0] rxByte;
  logic done;
  logic busy;
  logic [2:0] rate;
  logic master;
  logic enable;
  logic pol;
  logic phase;
  logic selected;
  logic selFall;

  modport core (
    output start, txByte, rate, master, enable, pol, phase, selected,
    output selFall,
    input rxByte, done, busy
  );
  modport engine (
    input start, txByte, rate, master, enable, pol, phase, selected,
    input selFall,
    output rxByte, done, busy
  );
endinterface

// [core/smsp_shift_engine.sv]
// Shift engine: baud divider, serial clock, eight-bit shift register.
// Assumes serial inputs already synchronous to clock; the core passes them in unsynchronised.
`timescale 1ns/100ps

module smsp_shift_engine (
  // Clock and reset.
  input wire logic clock,
  input wire logic sys_rst,
  // Core side.
  smsp_shift_if.engine sh,
  // Serial side, unsynchronised.
  input wire logic sckIn,
  input wire logic mosiIn,
  input wire logic misoIn,
  output logic sckOut,
  output logic mosiOut,
  output logic misoOut
);
  import smsp_pkg::*;

  smsp_state_t state_q;
  smsp_byte_t shift_q;
  logic [3:0] bitCnt_q;
  logic [6:0] divCnt_q;
  logic [6:0] halfDiv;
  logic sckPrev_q;
  logic inBit_q;
  logic edgeLead;
  logic edgeTrail;
  logic tick;
  logic rateOk;
  logic lastBit;

  // Half of the divisor per serial clock phase: codes 1..6 give 4..128.
  assign rateOk = (sh.rate != 3'h0) && (sh.rate != 3'h7);
  assign halfDiv = 7'(7'h01 << sh.rate) - 7'h01;
  assign tick = sh.master && (divCnt_q == halfDiv);
  // Slave edges are seen on the external clock relative to idle level.
  assign edgeLead = sh.master ? tick && (state_q == SMSP_LEAD)
                   : (sckIn != sckPrev_q) && (sckIn != sh.pol);
  assign edgeTrail = sh.master ? tick && (state_q == SMSP_TRAIL)
                    : (sckIn != sckPrev_q) && (sckIn == sh.pol);
  assign lastBit = (bitCnt_q == `SMSP_BITS_PER_BYTE - 4'h1);

  // Baud divider runs while any transfer is under way; it ticks only as master.
  always_ff @(posedge clock) begin
    if (sys_rst || state_q == SMSP_IDLE || tick)
      divCnt_q <= 7'h00;
    else
      divCnt_q <= divCnt_q + 7'h01;
  end

  always_ff @(posedge clock) begin
    sckPrev_q <= sys_rst ? 1'b0 : sckIn;
  end

  // Transfer sequencer; MSB first both ways, sample edge set by phase.
  always_ff @(posedge clock) begin
    sh.done <= 1'b0;
    if (sys_rst || !sh.enable || (!sh.master && !sh.selected)) begin
      state_q <= SMSP_IDLE;
      bitCnt_q <= 4'h0;
      if (sys_rst)
        shift_q <= 8'h00;
      sckOut <= sh.pol;
      inBit_q <= 1'b0;
    end else begin
      unique case (state_q)
        SMSP_IDLE: begin
          sckOut <= sh.pol;
          bitCnt_q <= 4'h0;
          if (sh.start && sh.master && rateOk) begin
            shift_q <= sh.txByte;
            state_q <= SMSP_LEAD;
          end else if (!sh.master && sh.phase && edgeLead) begin
            // Phase 1 slave: the first edge is the start, so go on to
            // the sampling edge rather than wait for a second lead.
            state_q <= SMSP_TRAIL;
          end else if (!sh.master && !sh.phase && sh.selFall) begin
            state_q <= SMSP_LEAD;
          end
        end
        SMSP_LEAD: begin
          if (sh.master && tick)
            sckOut <= ~sh.pol;
          if (edgeLead) begin
            if (!sh.phase)
              inBit_q <= sh.master ? misoIn : mosiIn;
            else if (bitCnt_q != 4'h0)
              shift_q <= {shift_q[6:0], inBit_q};
            state_q <= SMSP_TRAIL;
          end
        end
        SMSP_TRAIL: begin
          if (sh.master && tick)
            sckOut <= sh.pol;
          if (edgeTrail) begin
            if (sh.phase)
              inBit_q <= sh.master ? misoIn : mosiIn;
            else
              shift_q <= {shift_q[6:0], inBit_q};
            bitCnt_q <= bitCnt_q + 4'h1;
            if (lastBit) begin
              state_q <= SMSP_IDLE;
              sh.done <= 1'b1;
            end else
              state_q <= SMSP_LEAD;
          end
        end
        default: state_q <= SMSP_IDLE;
      endcase
    end
  end

  // Out bit is the shift register MSB. In phase 1 the last sampled bit
  // waits in inBit_q, so the output never moves on a sampling edge.
  assign mosiOut = shift_q[7];
  assign misoOut = shift_q[7];
  assign sh.rxByte = sh.phase ? {shift_q[6:0], inBit_q} : shift_q;
  assign sh.busy = (state_q != SMSP_IDLE);
endmodule

// [core/smsp_port.sv]
// Top of the SPI master/slave port: APB slave, control and status
// registers, select logic and pin drivers around the shift engine.
// Assumes APB master on clock, serial pins synchronous to clock.
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`include "smsp_consts.svh"

// Function
// - Each transfer moves eight bits each way, most significant bit first.
// - As master, exactly eight serial clock cycles per transfer.
// - Unselected slave floats its data output and stays out of traffic.
// - Master with select disabled ignores select; no mode fault from it.
// - Slave with phase and select-disable set counts as always selected.
// - Clearing select-disable leaves a pending mode fault standing.
// - Phase-0 slave starts on falling select; select-disable has no effect.
// - Rate codes 1 to 6 divide clock by 4 to 128; 0, 7 none.
// - Master-select bit picks master or slave; only master starts transfers.
// - Master data write loads shift register at once and starts shifting.
// - Master end sets done flag and copies received byte same cycle.
// - Done flag clears by status read with flag set, then data read.
// - Slave full byte moves to receive register and sets done flag.
// - Slave data write is never loaded; a slave sends leftover shift register contents.
// - Polarity sets idle clock level; phase picks sampling edges.
// - Master low select sets mode fault, clears enable and master bits.
// - Mode fault clears by status read with it set, then control write.
// - Data write during transfer sets collision flag, transfer unharmed.
// - Phase 0 samples leaving idle; phase 1 samples returning to idle.
module smsp_port (
  // Clock and reset.
  input wire logic clock,
  input wire logic sys_rst,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial clock pin.
  input wire logic sckIn,
  output logic sckOut,
  output logic sckOe,
  // Master out, slave in pin.
  input wire logic mosiIn,
  output logic mosiOut,
  output logic mosiOe,
  // Master in, slave out pin.
  input wire logic misoIn,
  output logic misoOut,
  output logic misoOe,
  // Active low select pin.
  input wire logic selIn_n
);
  import smsp_pkg::*;

  smsp_shift_if sh();

  logic [7:0] ctrl_q;
  smsp_byte_t rxData_q;
  smsp_byte_t txData_q;
  logic txPend_q;
  logic done_q;
  logic write_collision_flag_q;
  logic mode_fault_flag_q;
  logic doneArm_q;
  logic wcolArm_q;
  logic modfArm_q;
  logic selSync1_q;
  logic selSync2_q;
  logic selPrev_q;
  logic [7:0] pwCtrl;
  logic apbAccess;
  logic isCtrl;
  logic isStat;
  logic isData;
  logic mapped;
  logic wrCtrl;
  logic wrData;
  logic rdStat;
  logic rdData;
  logic accData;
  logic isMaster;
  logic isEnabled;
  logic selDis;
  logic selLow;
  logic modeFault;
  logic slaveSelected;
  logic engSck;
  logic engMosi;
  logic engMiso;
  logic [7:0] statVal;
  logic [7:0] rdMux;

  // APB decode; every access completes in its first access cycle.
  assign apbAccess = psel && penable;
  assign isCtrl = (paddr == `SMSP_OFF_CTRL);
  assign isStat = (paddr == `SMSP_OFF_STAT);
  assign isData = (paddr == `SMSP_OFF_DATA);
  assign mapped = isCtrl || isStat || isData;
  assign wrCtrl = apbAccess && pwrite && isCtrl;
  assign wrData = apbAccess && pwrite && isData;
  assign rdStat = apbAccess && !pwrite && isStat;
  assign rdData = apbAccess && !pwrite && isData;
  assign accData = apbAccess && isData;
  assign pwCtrl = pwdata[7:0];

  // Control field taps.
  assign isMaster = ctrl_q[`SMSP_CTRL_MASTER];
  assign isEnabled = ctrl_q[`SMSP_CTRL_ENABLE];
  assign selDis = ctrl_q[`SMSP_CTRL_SELDIS];
  assign selLow = !selSync2_q;
  // Master ignores select when disabled; it is then a spare pin.
  assign modeFault = isEnabled && isMaster && !selDis && selLow;
  // Select-disable only frees a slave in phase 1; phase 0 needs the edge.
  assign slaveSelected = selLow ||
      (selDis && ctrl_q[`SMSP_CTRL_PHASE]);

  // Select pin synchroniser; the second stage and its delayed copy are used.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      selSync1_q <= 1'b1;
      selSync2_q <= 1'b1;
      selPrev_q <= 1'b1;
    end else begin
      selSync1_q <= selIn_n;
      selSync2_q <= selSync1_q;
      selPrev_q <= selSync2_q;
    end
  end

  // Control register; mode fault drops enable and master, and wins.
  always_ff @(posedge clock) begin
    if (sys_rst)
      ctrl_q <= `SMSP_CTRL_RESET;
    else if (modeFault) begin
      ctrl_q[`SMSP_CTRL_ENABLE] <= 1'b0;
      ctrl_q[`SMSP_CTRL_MASTER] <= 1'b0;
    end else if (wrCtrl)
      ctrl_q <= pwCtrl;
  end

  // Transmit holding: a master write starts at once when the engine
  // is idle; a slave write is dropped once the next byte begins.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      txData_q <= 8'h00;
      txPend_q <= 1'b0;
    end else begin
      if (wrData && !sh.busy) begin
        txData_q <= pwdata[7:0];
        txPend_q <= 1'b1;
      end else if (sh.start || (!isMaster && sh.busy))
        txPend_q <= 1'b0;
    end
  end

  // Engine load: master starts on the pending byte; a slave never loads
  // it, so its shift register sends the leftover byte.
  assign sh.start = txPend_q && !sh.busy &&
      (isMaster ? isEnabled : 1'b0);
  assign sh.txByte = txData_q;
  assign sh.rate = {ctrl_q[`SMSP_CTRL_RATE_HI],
      ctrl_q[`SMSP_CTRL_RATE_MID], ctrl_q[`SMSP_CTRL_RATE_LO]};
  assign sh.master = isMaster;
  assign sh.enable = isEnabled;
  assign sh.pol = ctrl_q[`SMSP_CTRL_POL];
  assign sh.phase = ctrl_q[`SMSP_CTRL_PHASE];
  assign sh.selected = slaveSelected;
  assign sh.selFall = selPrev_q && !selSync2_q;

  // Receive register taken in the cycle the engine reports the end.
  always_ff @(posedge clock) begin
    if (sys_rst)
      rxData_q <= 8'h00;
    else if (sh.done)
      rxData_q <= sh.rxByte;
  end

  // Done flag: status read arms, data read clears; a new end wins.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      done_q <= 1'b0;
      doneArm_q <= 1'b0;
    end else if (sh.done) begin
      done_q <= 1'b1;
      doneArm_q <= 1'b0;
    end else if (rdData && doneArm_q) begin
      done_q <= 1'b0;
      doneArm_q <= 1'b0;
    end else if (rdStat && done_q)
      doneArm_q <= 1'b1;
  end

  // Collision flag: set by a data write while busy; status then data.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      write_collision_flag_q <= 1'b0;
      wcolArm_q <= 1'b0;
    end else if (wrData && sh.busy) begin
      write_collision_flag_q <= 1'b1;
      wcolArm_q <= 1'b0;
    end else if (accData && wcolArm_q) begin
      write_collision_flag_q <= 1'b0;
      wcolArm_q <= 1'b0;
    end else if (rdStat && write_collision_flag_q)
      wcolArm_q <= 1'b1;
  end

  // Mode fault: cleared only by status read then control write, never
  // by the select-disable bit itself.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mode_fault_flag_q <= 1'b0;
      modfArm_q <= 1'b0;
    end else if (modeFault) begin
      mode_fault_flag_q <= 1'b1;
      modfArm_q <= 1'b0;
    end else if (wrCtrl && modfArm_q) begin
      mode_fault_flag_q <= 1'b0;
      modfArm_q <= 1'b0;
    end else if (rdStat && mode_fault_flag_q)
      modfArm_q <= 1'b1;
  end

  // Read multiplexer.
  assign statVal = {done_q, write_collision_flag_q, 1'b0, mode_fault_flag_q, 4'h0};
  assign rdMux = isCtrl ? ctrl_q : isStat ? statVal :
      isData ? rxData_q : 8'h00;

  // APB answer registered: ready in the first access cycle.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= (psel && !penable && !pwrite) ? {24'h00_0000, rdMux}
          : 32'h0000_0000;
    end
  end

  smsp_shift_engine u_engine (
    .clock(clock),
    .sys_rst(sys_rst),
    .sh(sh),
    .sckIn(sckIn),
    .mosiIn(mosiIn),
    .misoIn(misoIn),
    .sckOut(engSck),
    .mosiOut(engMosi),
    .misoOut(engMiso)
  );

  // Pin drivers registered; master drives clock and data out, slave
  // drives its data output only while selected and enabled.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sckOut <= 1'b0;
      sckOe <= 1'b0;
      mosiOut <= 1'b0;
      mosiOe <= 1'b0;
      misoOut <= 1'b0;
      misoOe <= 1'b0;
    end else begin
      sckOut <= engSck;
      sckOe <= isEnabled && isMaster;
      mosiOut <= engMosi;
      mosiOe <= isEnabled && isMaster;
      misoOut <= engMiso;
      misoOe <= isEnabled && !isMaster && slaveSelected;
    end
  end
endmodule

// [bench/smsp_port_properties.sv]
// Concurrent checks on the SPI port's APB answer and pin enables.
// Assumes it is bound to the port top and sees only its ports.
`timescale 1ns/100ps
`include "smsp_consts.svh"

module smsp_port_properties (
  // Clock and reset.
  input wire logic clock,
  input wire logic sys_rst,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Serial pins.
  input wire logic sckOut,
  input wire logic sckOe,
  input wire logic mosiOe,
  input wire logic misoOe,
  input wire logic selIn_n
);
  logic [7:0] ctrlQ;
  wire logic wrCtrl = pready && pwrite && paddr == `SMSP_OFF_CTRL;
  wire logic mapped = paddr inside {`SMSP_OFF_CTRL, `SMSP_OFF_STAT,
    `SMSP_OFF_DATA};
  wire logic badRate = {ctrlQ[7], ctrlQ[1:0]} inside {3'h0, 3'h7};
  wire logic master = ctrlQ[6] && ctrlQ[4];

  // Shadow of the control word; faults are not mirrored, so it is only
  // used where a fault cannot turn the condition false.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctrlQ <= 8'h00;
    end else if (psel && penable && wrCtrl) begin
      ctrlQ <= pwdata[7:0];
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence apbSetup;
    psel && !penable;
  endsequence
  sequence faultHeld;
    (master && !ctrlQ[5] && !selIn_n) [*7];
  endsequence

  // The answer is fixed at one cycle after setup and lasts one cycle.
  a_ready_setup: assert property (apbSetup |=> pready)
    else $error("no ready after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_unmapped: assert property (pready |-> pslverr == !mapped)
    else $error("error flag wrong for address");
  a_read_high_zero: assert property (pready |-> prdata[31:8] == 24'h00_0000)
    else $error("upper read data not zero");
  a_mode_excl: assert property (sckOe |-> !misoOe)
    else $error("master and slave drivers both on");
  a_unsel_float: assert property (
    (!(ctrlQ[5] && ctrlQ[2]) && selIn_n) [*4] |-> !misoOe)
    else $error("unselected slave drives data");
  a_off_quiet: assert property ((!ctrlQ[6]) [*3] |->
    !sckOe && !mosiOe && !misoOe)
    else $error("disabled port drives pins");
  a_bad_rate_idle: assert property (
    (master && badRate) [*4] |-> $stable(sckOut))
    else $error("clock moves without divisor");
  a_fault_stop: assert property (faultHeld |-> !sckOe)
    else $error("master kept driving after fault");
endmodule

bind smsp_port smsp_port_properties u_smsp_port_properties (
  .clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .sckOut(sckOut), .sckOe(sckOe),
  .mosiOe(mosiOe), .misoOe(misoOe), .selIn_n(selIn_n));

// [bench/smsp_slave_model.sv]
// Behavioural SPI slave facing the port when the port is master.
// Assumes the bench supplies its select, polarity, phase and reply byte.
`timescale 1ns/100ps

module smsp_slave_model (
  // Serial pins.
  input wire logic sck,
  input wire logic mosi,
  input wire logic slvSel_n,
  output logic miso,
  // Format and data.
  input wire logic pol,
  input wire logic phase,
  input wire logic [7:0] txByte,
  output logic [7:0] rxByte,
  output int nEdges,
  output real halfTime
);
  logic [7:0] shiftQ;
  real lastEdge;

  // Loading on select fall puts the first bit out before any edge.
  always @(negedge slvSel_n) begin
    nEdges = 0;
    shiftQ = txByte;
    miso = txByte[7];
  end
  // A released line shows the inverse of its last bit, not a held value.
  always @(posedge slvSel_n) miso = ~miso;

  // Sampling edge depends on phase; the other edge moves the next bit.
  always @(sck) begin
    if (!slvSel_n) begin
      if (nEdges == 1) halfTime = $realtime - lastEdge;
      lastEdge = $realtime;
      nEdges++;
      if ((sck != pol) ^ phase) begin
        rxByte = {rxByte[6:0], mosi};
      end else if (phase) begin
        miso = shiftQ[7];
        shiftQ = shiftQ << 1;
      end else begin
        shiftQ = shiftQ << 1;
        miso = shiftQ[7];
      end
    end
  end
endmodule

// [bench/spi_master_slave_port_tb_top.sv]
// Self-checking bench for the SPI port with a slave model on its pins.
// Assumes the design, its package and the checker compile first.
`timescale 1ns/100ps
`include "smsp_consts.svh"

module spi_master_slave_port_tb_top;
  import smsp_pkg::*;
  localparam logic [11:0] offCtrl = `SMSP_OFF_CTRL;
  localparam logic [11:0] offStat = `SMSP_OFF_STAT;
  localparam logic [11:0] offData = `SMSP_OFF_DATA;
  logic clock, sys_rst, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic sckOut, sckOe, mosiOut, mosiOe, misoOut, misoOe, slvMiso;
  logic selIn_n, slvSel_n, pol, phase, extSck, extMosi;
  smsp_byte_t slvTx, slvRx, txB;
  smsp_byte_t expQ[$];
  int badCount, nChecks, slvEdges;
  real slvHalf;
  // Pin levels; the bench acts as external master when the port is slave.
  wire logic sckWire = sckOe ? sckOut : extSck;
  wire logic mosiWire = mosiOe ? mosiOut : extMosi;
  wire logic misoWire = misoOe ? misoOut : slvMiso;

  smsp_port u_smsp_port (
    .clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sckIn(sckWire), .sckOut(sckOut),
    .sckOe(sckOe), .mosiIn(mosiWire), .mosiOut(mosiOut), .mosiOe(mosiOe),
    .misoIn(misoWire), .misoOut(misoOut), .misoOe(misoOe),
    .selIn_n(selIn_n));
  smsp_slave_model u_smsp_slave_model (
    .sck(sckWire), .mosi(mosiWire), .slvSel_n(slvSel_n), .miso(slvMiso),
    .pol(pol), .phase(phase), .txByte(slvTx), .rxByte(slvRx),
    .nEdges(slvEdges), .halfTime(slvHalf));

  // Free-running 250 MHz clock.
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // Compare one result and count it.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      badCount++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; the idle cycle after it keeps drivers race free.
  task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) badCount++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  // Poll status until the done flag shows, under a bound.
  task automatic waitDone;
    int n;
    n = 0;
    do begin
      apb(1'b0, offStat, 32'h0000_0000);
      n++;
    end while (rd[7] !== 1'b1 && n < 500);
    if (n >= 500) badCount++;
  endtask

  // One master transfer, optionally with a colliding second write.
  task automatic xfer(input logic [2:0] code, input logic write_collision_flag);
    int div;
    div = 2 << code;
    apb(1'b1, offCtrl, 32'h0000_0000);
    apb(1'b1, offCtrl, 32'({code[2], 3'b001, pol, phase, code[1:0]}));
    apb(1'b1, offCtrl, 32'({code[2], 3'b101, pol, phase, code[1:0]}));
    slvTx = 8'($urandom);
    txB = 8'($urandom);
    expQ.push_back(slvTx);
    // The clock pin reaches its idle level before the slave is selected.
    @(posedge clock);
    slvSel_n <= 1'b0;
    apb(1'b1, offData, 32'(txB));
    if (write_collision_flag) apb(1'b1, offData, 32'(~txB));
    waitDone;
    check(32'({rd[7:6], rd[4]}), 32'({1'b1, write_collision_flag, 1'b0}));
    check(32'(slvRx), 32'(txB));
    check(slvEdges, 16);
    check(32'(int'(slvHalf)), div * 2);
    apb(1'b0, offData, 32'h0000_0000);
    check(rd, 32'(expQ.pop_front()));
    apb(1'b0, offStat, 32'h0000_0000);
    check(32'(rd[7:6]), 0);
    slvSel_n <= 1'b1;
  endtask

  // Main sequence: reset, transfers, faults, slave enables.
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {selIn_n, slvSel_n, sys_rst} = 3'h7;
    {pol, phase, slvTx, extSck, extMosi} = '0;
    void'($urandom(32'h0000_cc5b));
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    apb(1'b0, offCtrl, 32'h0000_0000);
    check(rd, 0);
    apb(1'b0, 12'h00c, 32'h0000_0000);
    check({rd[31:1], err}, 32'h0000_0001);
    $display("reset and map test done");
    for (int i = 0; i < 6; i++) begin
      {phase, pol} = 2'(i);
      xfer(3'(i + 1), 1'b0);
    end
    {phase, pol} = 2'h0;
    xfer(3'h1, 1'b1);
    $display("transfer test done");
    for (int c = 0; c < 8; c += 7) begin
      apb(1'b1, offCtrl, 32'h0000_0000);
      apb(1'b1, offCtrl, 32'({c[2], 5'b10100, c[1:0]}));
      apb(1'b1, offData, 32'h0000_005a);
      repeat (300) @(posedge clock);
      apb(1'b0, offStat, 32'h0000_0000);
      check(32'(rd[7]), 0);
    end
    apb(1'b1, offCtrl, 32'h0000_0050);
    selIn_n <= 1'b0;
    repeat (8) @(posedge clock);
    selIn_n <= 1'b1;
    apb(1'b0, offCtrl, 32'h0000_0000);
    check(32'(rd[6:4]), 0);
    apb(1'b1, offCtrl, 32'h0000_0000);
    apb(1'b0, offStat, 32'h0000_0000);
    check(32'(rd[4]), 1);
    apb(1'b1, offCtrl, 32'h0000_0000);
    apb(1'b0, offStat, 32'h0000_0000);
    check(32'(rd[4]), 0);
    apb(1'b1, offCtrl, 32'h0000_0070);
    selIn_n <= 1'b0;
    repeat (8) @(posedge clock);
    apb(1'b0, offStat, 32'h0000_0000);
    check(32'(rd[4]), 0);
    selIn_n <= 1'b1;
    apb(1'b1, offCtrl, 32'h0000_0040);
    repeat (6) @(posedge clock);
    check(32'({misoOe, sckOe}), 0);
    selIn_n <= 1'b0;
    repeat (6) @(posedge clock);
    check(32'(misoOe), 1);
    // External master sends one byte at an eighth of our clock rate.
    txB = 8'($urandom);
    for (int b = 7; b >= 0; b--) begin
      extMosi <= txB[b];
      repeat (4) @(posedge clock);
      extSck <= 1'b1;
      repeat (4) @(posedge clock);
      extSck <= 1'b0;
    end
    repeat (4) @(posedge clock);
    waitDone;
    apb(1'b0, offData, 32'h0000_0000);
    check(rd, 32'(txB));
    $display("fault and slave test done");
    reportAndStop;
  end

  // Watchdog sized well above the longest expected run.
  initial begin
    #200000;
    badCount++;
    reportAndStop;
  end

  task automatic reportAndStop;
    $display("checks %0d mismatches %0d", nChecks, badCount);
    if (badCount == 0 && nChecks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
endmodule
